// [core/tcs_flag_cell.sv]
// one status flag cleared by read-as-one then write-zero
`timescale 1ns/1ps
module tcs_flag_cell
  import tcs_pkg::*;
#(
  parameter bit PRESENT = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // hardware side
  input wire logic set_event,
  input wire logic hw_clear,
  // software side
  input wire logic sw_read,
  input wire logic sw_write,
  input wire logic sw_write_zero,
  // flag
  output logic flag
);

  logic armed;

  // set beats any clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (!PRESENT) begin
        flag <= 1'b0;
      end else if (set_event) begin
        flag <= 1'b1;
      end else if (hw_clear) begin
        flag <= 1'b0;
      end else if (sw_write && sw_write_zero && armed) begin // [RULE3] [RULE8]
        flag <= 1'b0;
      end
    end
  end

  // a write consumes the arming; an unarmed zero or any one does nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b0;
    end else if (ce) begin
      if (sw_read && flag) begin
        armed <= 1'b1;
      end else if (sw_write) begin // [RULE9]
        armed <= 1'b0;
      end
    end
  end

endmodule : tcs_flag_cell

// [core/tcs_irq_bits.sv]
// sticky event bits, write-one clear, enable mask and level interrupt
`timescale 1ns/1ps
module tcs_irq_bits
  import tcs_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // events
  input wire logic [INT_W-1:0] events,
  // software
  input wire logic clear_wr,
  input wire logic [INT_W-1:0] clear_data,
  input wire logic enable_wr,
  input wire logic [INT_W-1:0] enable_data,
  // state
  output logic [INT_W-1:0] status,
  output logic [INT_W-1:0] enable,
  output logic irq
);

  logic [INT_W-1:0] next_status;

  always_comb begin
    next_status = status;
    if (clear_wr) begin
      next_status = next_status & ~clear_data;
    end
    // an event in the clearing cycle survives
    next_status = next_status | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= INT_STATUS_RESET;
    end else if (ce) begin
      status <= next_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= INT_ENABLE_RESET;
    end else if (ce && enable_wr) begin
      enable <= enable_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(next_status & (enable_wr ? enable_data : enable));
    end
  end

endmodule : tcs_irq_bits

// [core/tcs_status_flags.sv]
// status flags of one timer channel with an AXI4-Lite register slave
//
// Contract
// RULE1 - the underflow flag sets when the counter steps from all zeros to all ones.
// RULE2 - the underflow flag exists only on channels 1, 2, 4 and 5, in phase counting mode.
// RULE3 - a zero written to the underflow flag clears it once it was read as one.
// RULE4 - the compare/capture flag A sets when the counter equals register A in compare mode.
// RULE5 - in capture mode the compare/capture flag A sets when a capture loads register A.
// RULE6 - a transfer controller started by the channel A request with select zero clears flag A.
// RULE7 - on the older device a DMA start with transfer enable zero also clears flag A.
// RULE8 - a zero written to flag A clears it once it was read as one.
// RULE9 - an unarmed zero write and any write of one leave a flag unchanged.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module tcs_status_flags
  import tcs_pkg::*;
#(
  parameter int CHANNEL_INDEX = 1
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // counter and register a datapath
  input wire logic [COUNTER_W-1:0] channel_counter,
  input wire logic [COUNTER_W-1:0] general_register_a,
  input wire logic gra_capture_mode,
  input wire logic capture_strobe,
  input wire logic phase_counting_mode,
  // transfer controllers
  input wire logic data_transfer_ctrl_start,
  input wire logic transfer_interrupt_select,
  input wire logic dma_start,
  input wire logic dma_transfer_enable,
  // flags and requests
  output logic compare_capture_flag_a,
  output logic underflow_flag,
  output logic channel_a_interrupt,
  output logic irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam bit UNDERFLOW_PRESENT = (CHANNEL_INDEX >= 0) && (CHANNEL_INDEX < 8)
                                     && UNDERFLOW_CHANNELS[CHANNEL_INDEX[2:0]];

  tcs_wr_state_t wr_state;
  tcs_rd_state_t rd_state;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_held;
  logic w_held;
  logic wr_fire;
  logic rd_fire;
  logic wr_lane0;
  logic status_wr;
  logic status_rd;
  logic int_clear_wr;
  logic int_enable_wr;
  logic config_wr;
  logic wr_mapped;
  logic rd_mapped;
  logic [DATA_W-1:0] rd_value;

  logic [CONFIG_W-1:0] config_bits;
  logic [COUNTER_W-1:0] counter_prev;
  logic counter_prev_valid;
  logic match_prev;
  logic match_now;
  logic underflow_event;
  logic compare_event;
  logic capture_event;
  logic dtc_clear;
  logic dma_clear;
  logic xfer_clear;

  logic [FLAG_N-1:0] flag_set;
  logic [FLAG_N-1:0] flag_hw_clear;
  logic [FLAG_N-1:0] flag_value;
  logic [FLAG_N-1:0] flag_wr_zero;
  logic [INT_W-1:0] int_events;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_enable;
  logic [STATUS_W-1:0] status_value;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  assign wr_fire = (wr_state == WR_COLLECT) && aw_held && w_held;

  // address and data are taken in either order and held for the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
      wr_addr <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_held <= 1'b0;
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_held <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      case (wr_state)
        WR_COLLECT: begin
          if (wr_fire) begin
            wr_state <= WR_RESPOND;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESPOND: begin
          if (s_axi_bready) begin
            wr_state <= WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= WR_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // all fields sit in byte lane 0; other lanes are ignored
  assign wr_lane0 = wr_fire && wr_strb[0];
  assign status_wr = wr_lane0 && (wr_addr[AXI_ADDR_W-1:2] == ADDR_STATUS[AXI_ADDR_W-1:2]);
  assign int_clear_wr = wr_lane0
                        && (wr_addr[AXI_ADDR_W-1:2] == ADDR_INT_CLEAR[AXI_ADDR_W-1:2]);
  assign int_enable_wr = wr_lane0
                         && (wr_addr[AXI_ADDR_W-1:2] == ADDR_INT_ENABLE[AXI_ADDR_W-1:2]);
  assign config_wr = wr_lane0 && (wr_addr[AXI_ADDR_W-1:2] == ADDR_CONFIG[AXI_ADDR_W-1:2]);

  always_comb begin
    case (wr_addr[AXI_ADDR_W-1:2])
      ADDR_STATUS[AXI_ADDR_W-1:2],
      ADDR_INT_CLEAR[AXI_ADDR_W-1:2],
      ADDR_INT_ENABLE[AXI_ADDR_W-1:2],
      ADDR_CONFIG[AXI_ADDR_W-1:2]: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_bits <= CONFIG_RESET;
    end else if (ce && config_wr) begin
      config_bits <= wr_data[CONFIG_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign status_rd = rd_fire
                     && (s_axi_araddr[AXI_ADDR_W-1:2] == ADDR_STATUS[AXI_ADDR_W-1:2]);

  always_comb begin
    rd_value = '0;
    rd_mapped = 1'b1;
    case (s_axi_araddr[AXI_ADDR_W-1:2])
      ADDR_STATUS[AXI_ADDR_W-1:2]: rd_value[STATUS_W-1:0] = status_value;
      ADDR_INT_STATUS[AXI_ADDR_W-1:2]: rd_value[INT_W-1:0] = int_status;
      ADDR_INT_CLEAR[AXI_ADDR_W-1:2]: rd_value = '0;
      ADDR_INT_ENABLE[AXI_ADDR_W-1:2]: rd_value[INT_W-1:0] = int_enable;
      ADDR_CONFIG[AXI_ADDR_W-1:2]: rd_value[CONFIG_W-1:0] = config_bits;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      case (rd_state)
        RD_IDLE: begin
          if (rd_fire) begin
            rd_state <= RD_VALID;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        RD_VALID: begin
          if (s_axi_rready) begin
            rd_state <= RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
          s_axi_arready <= 1'b1;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // counter events
  // ---------------------------------------------------------------
  // a wrap is seen only across two sampled values, so a reset load of
  // all ones is not taken for an underflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_prev <= COUNTER_ALL_ZERO;
      counter_prev_valid <= 1'b0;
      match_prev <= 1'b0;
    end else if (ce) begin
      counter_prev <= channel_counter;
      counter_prev_valid <= 1'b1;
      match_prev <= match_now;
    end
  end

  assign underflow_event = counter_prev_valid && phase_counting_mode // [RULE2]
                           && (counter_prev == COUNTER_ALL_ZERO)
                           && (channel_counter == COUNTER_ALL_ONES); // [RULE1]

  // a slow count clock holds a match for many cycles; only its start counts
  assign match_now = !gra_capture_mode && (channel_counter == general_register_a);
  assign compare_event = match_now && !match_prev; // [RULE4]
  assign capture_event = gra_capture_mode && capture_strobe; // [RULE5]

  // ---------------------------------------------------------------
  // transfer controller clears
  // ---------------------------------------------------------------
  assign dtc_clear = data_transfer_ctrl_start && channel_a_interrupt
                     && !transfer_interrupt_select; // [RULE6]
  assign dma_clear = config_bits[CONFIG_DMA_CLEAR_POS] && dma_start && channel_a_interrupt
                     && !dma_transfer_enable; // [RULE7]
  assign xfer_clear = dtc_clear || dma_clear;

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  assign flag_set[FLAG_CCFA_IDX] = compare_event || capture_event;
  assign flag_set[FLAG_UNDERFLOW_IDX] = underflow_event;
  assign flag_hw_clear[FLAG_CCFA_IDX] = xfer_clear;
  assign flag_hw_clear[FLAG_UNDERFLOW_IDX] = 1'b0;
  assign flag_wr_zero[FLAG_CCFA_IDX] = !wr_data[STATUS_CCFA_POS];
  assign flag_wr_zero[FLAG_UNDERFLOW_IDX] = !wr_data[STATUS_UNDERFLOW_POS];

  genvar gi;
  generate
    for (gi = 0; gi < FLAG_N; gi = gi + 1) begin : g_flag
      tcs_flag_cell #(
        .PRESENT((gi == FLAG_UNDERFLOW_IDX) ? UNDERFLOW_PRESENT : 1'b1) // [RULE2]
      ) u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .set_event(flag_set[gi]),
        .hw_clear(flag_hw_clear[gi]),
        .sw_read(status_rd),
        .sw_write(status_wr),
        .sw_write_zero(flag_wr_zero[gi]),
        .flag(flag_value[gi])
      );
    end
  endgenerate

  assign compare_capture_flag_a = flag_value[FLAG_CCFA_IDX];
  assign underflow_flag = flag_value[FLAG_UNDERFLOW_IDX];

  always_comb begin
    status_value = '0;
    status_value[STATUS_CCFA_POS] = flag_value[FLAG_CCFA_IDX];
    status_value[STATUS_UNDERFLOW_POS] = flag_value[FLAG_UNDERFLOW_IDX];
  end

  // request to the transfer controllers follows flag a when enabled; any zero write to flag a, armed or not, drops it for a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_a_interrupt <= 1'b0;
    end else if (ce) begin
      channel_a_interrupt <= config_bits[CONFIG_REQ_ENABLE_POS]
                             && (flag_set[FLAG_CCFA_IDX] || (compare_capture_flag_a
                             && !xfer_clear
                             && !(status_wr && flag_wr_zero[FLAG_CCFA_IDX])));
    end
  end

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  always_comb begin
    int_events = '0;
    int_events[INT_CCFA_SET_POS] = flag_set[FLAG_CCFA_IDX];
    int_events[INT_UNDERFLOW_SET_POS] = flag_set[FLAG_UNDERFLOW_IDX] && UNDERFLOW_PRESENT;
    int_events[INT_XFER_CLEAR_POS] = xfer_clear;
  end

  tcs_irq_bits u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .events(int_events),
    .clear_wr(int_clear_wr),
    .clear_data(wr_data[INT_W-1:0]),
    .enable_wr(int_enable_wr),
    .enable_data(wr_data[INT_W-1:0]),
    .status(int_status),
    .enable(int_enable),
    .irq(irq)
  );

endmodule : tcs_status_flags

// [pkg/tcs_pkg.sv]
// constants and types shared by the timer channel status flag block
package tcs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int COUNTER_W = 16;
  localparam int STATUS_W = 8;
  localparam int INT_W = 3;
  localparam int FLAG_N = 2;

  // ---------------------------------------------------------------
  // counter values
  // ---------------------------------------------------------------
  localparam logic [COUNTER_W-1:0] COUNTER_ALL_ZERO = 16'h0000;
  localparam logic [COUNTER_W-1:0] COUNTER_ALL_ONES = 16'hffff;
  // channels that carry an underflow flag: 1, 2, 4 and 5
  localparam logic [7:0] UNDERFLOW_CHANNELS = 8'h36;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AXI_ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] ADDR_INT_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] ADDR_INT_CLEAR = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] ADDR_INT_ENABLE = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] ADDR_CONFIG = 8'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STATUS_CCFA_POS = 0;
  localparam int STATUS_UNDERFLOW_POS = 5;
  localparam int FLAG_CCFA_IDX = 0;
  localparam int FLAG_UNDERFLOW_IDX = 1;
  localparam int INT_CCFA_SET_POS = 0;
  localparam int INT_UNDERFLOW_SET_POS = 1;
  localparam int INT_XFER_CLEAR_POS = 2;
  localparam int CONFIG_W = 2;
  localparam int CONFIG_DMA_CLEAR_POS = 0;
  localparam int CONFIG_REQ_ENABLE_POS = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [INT_W-1:0] INT_STATUS_RESET = 3'h0;
  localparam logic [INT_W-1:0] INT_ENABLE_RESET = 3'h0;
  localparam logic [CONFIG_W-1:0] CONFIG_RESET = 2'h3;

  // ---------------------------------------------------------------
  // bus responses and states
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESPOND = 2'h2
  } tcs_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_VALID = 2'h2
  } tcs_rd_state_t;

endpackage : tcs_pkg

// [tb/tcs_status_flags_bench.sv]
// self-checking bench for the timer channel status flags
`timescale 1ns/1ps
module tcs_status_flags_bench
  import tcs_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [COUNTER_W-1:0] channel_counter = 16'h0100, general_register_a = 16'h4000;
  logic gra_capture_mode = 1'b0, capture_strobe = 1'b0, phase_counting_mode = 1'b0;
  logic transfer_interrupt_select = 1'b1, dma_transfer_enable = 1'b1;
  logic go_dtc = 1'b0, go_dma = 1'b0, data_transfer_ctrl_start, dma_start;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic compare_capture_flag_a, underflow_flag, channel_a_interrupt, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [DATA_W-1:0] s_axi_rdata;
  int err_total = 0, checks = 0;

  tcs_status_flags u_dut (.*);
  tcs_xfer_model u_xfer (.*);
  always #20 aclk = ~aclk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : axi_wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd

  // one-cycle match of counter and register a
  task automatic hit;
    @(posedge aclk);
    channel_counter <= general_register_a;
    @(posedge aclk);
    channel_counter <= 16'h0100;
    tick(2);
  endtask : hit

  task automatic ramp;
    @(posedge aclk);
    channel_counter <= 16'h0000;
    @(posedge aclk);
    channel_counter <= 16'hffff;
    @(posedge aclk);
    channel_counter <= 16'h0100;
    tick(1);
  endtask : ramp

  task automatic sw_clear(input logic [31:0] e);
    rd(ADDR_STATUS, e, RESP_OKAY);
    axi_wr(ADDR_STATUS, 32'h0, RESP_OKAY);
  endtask : sw_clear

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_CONFIG, 32'(CONFIG_RESET), RESP_OKAY);
    rd(ADDR_INT_ENABLE, 32'h0, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    axi_wr(8'h14, 32'h1, RESP_SLVERR);
  endtask : t_reset

  task automatic t_compare;
    hit();
    chk("flag_a", 32'(compare_capture_flag_a), 32'h1);
    axi_wr(ADDR_STATUS, 32'h0, RESP_OKAY);
    chk("flag_a", 32'(compare_capture_flag_a), 32'h1);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    axi_wr(ADDR_STATUS, 32'h1, RESP_OKAY);
    chk("flag_a", 32'(compare_capture_flag_a), 32'h1);
    sw_clear(32'h1);
    chk("flag_a", 32'(compare_capture_flag_a), 32'h0);
    rd(ADDR_INT_STATUS, 32'h1, RESP_OKAY);
  endtask : t_compare

  task automatic t_capture;
    gra_capture_mode <= 1'b1;
    hit();
    chk("flag_a", 32'(compare_capture_flag_a), 32'h0);
    @(posedge aclk);
    capture_strobe <= 1'b1;
    @(posedge aclk);
    capture_strobe <= 1'b0;
    tick(1);
    chk("flag_a", 32'(compare_capture_flag_a), 32'h1);
    gra_capture_mode <= 1'b0;
    sw_clear(32'h1);
  endtask : t_capture

  task automatic t_under;
    ramp();
    chk("underflow", 32'(underflow_flag), 32'h0);
    phase_counting_mode <= 1'b1;
    ramp();
    chk("underflow", 32'(underflow_flag), 32'h1);
    sw_clear(32'h20);
    chk("underflow", 32'(underflow_flag), 32'h0);
    phase_counting_mode <= 1'b0;
  endtask : t_under

  task automatic t_xfer;
    hit();
    go_dtc <= 1'b1;
    tick(8);
    chk("flag_a", 32'(compare_capture_flag_a), 32'h1);
    chk("req_a", 32'(channel_a_interrupt), 32'h1);
    go_dtc <= 1'b0;
    transfer_interrupt_select <= 1'b0;
    tick(1);
    go_dtc <= 1'b1;
    tick(8);
    chk("flag_a", 32'(compare_capture_flag_a), 32'h0);
    chk("req_a", 32'(channel_a_interrupt), 32'h0);
    go_dtc <= 1'b0;
    hit();
    dma_transfer_enable <= 1'b0;
    go_dma <= 1'b1;
    tick(8);
    chk("flag_a", 32'(compare_capture_flag_a), 32'h0);
    go_dma <= 1'b0;
    rd(ADDR_INT_STATUS, 32'h7, RESP_OKAY);
  endtask : t_xfer

  task automatic t_irq;
    axi_wr(ADDR_INT_ENABLE, 32'h4, RESP_OKAY);
    tick(2);
    chk("irq", 32'(irq), 32'h1);
    rd(ADDR_INT_ENABLE, 32'h4, RESP_OKAY);
    axi_wr(ADDR_INT_CLEAR, 32'h4, RESP_OKAY);
    tick(2);
    chk("irq", 32'(irq), 32'h0);
    rd(ADDR_INT_STATUS, 32'h3, RESP_OKAY);
    rd(ADDR_INT_CLEAR, 32'h0, RESP_OKAY);
  endtask : t_irq

  task automatic wrap_up;
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    tick(4);
    aresetn <= 1'b1;
    t_reset();
    t_compare();
    t_capture();
    t_under();
    t_xfer();
    t_irq();
    wrap_up();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    tick(5000);
    err_total++;
    wrap_up();
  end
endmodule : tcs_status_flags_bench

// [tb/tcs_status_flags_checker.sv]
// port-level assertions for the timer channel status flags
`timescale 1ns/1ps
module tcs_status_flags_checker
  import tcs_pkg::*;
#(
  parameter int CHANNEL_INDEX = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // datapath
  input wire logic [COUNTER_W-1:0] channel_counter,
  input wire logic [COUNTER_W-1:0] general_register_a,
  input wire logic gra_capture_mode,
  input wire logic capture_strobe,
  input wire logic phase_counting_mode,
  input wire logic data_transfer_ctrl_start,
  input wire logic transfer_interrupt_select,
  // flags
  input wire logic compare_capture_flag_a,
  input wire logic underflow_flag,
  input wire logic channel_a_interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic eq = channel_counter == general_register_a;
  wire logic uf_on = phase_counting_mode && UNDERFLOW_CHANNELS[CHANNEL_INDEX];

  compare_set_a: assert property (ce && !gra_capture_mode && eq && !$past(eq)
    |=> compare_capture_flag_a) else $error("flag a missed a compare match");
  capture_set_a: assert property (ce && gra_capture_mode && capture_strobe
    |=> compare_capture_flag_a) else $error("flag a missed a capture");
  underflow_set_a: assert property (ce && $past(ce) && $past(aresetn) && uf_on
    && channel_counter == COUNTER_ALL_ONES && $past(channel_counter) == COUNTER_ALL_ZERO
    |=> underflow_flag) else $error("underflow flag missed a wrap");
  underflow_gate_a: assert property (!uf_on && !underflow_flag |=> !underflow_flag)
    else $error("underflow flag set outside its mode");
  xfer_clear_a: assert property (ce && channel_a_interrupt && data_transfer_ctrl_start
    && !transfer_interrupt_select && !capture_strobe && !eq
    |=> !compare_capture_flag_a) else $error("transfer start left flag a set");
  flag_cause_a: assert property ($rose(compare_capture_flag_a)
    |-> $past(capture_strobe && gra_capture_mode) || $past(!gra_capture_mode && eq))
    else $error("flag a rose without a cause");
  uf_cause_a: assert property ($rose(underflow_flag)
    |-> $past(channel_counter) == COUNTER_ALL_ONES) else $error("underflow rose without wrap");
  write_resp_a: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  read_resp_a: assert property (ce && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read response late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");

  cover property (channel_a_interrupt && data_transfer_ctrl_start);
  cover property ($rose(underflow_flag));
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
endmodule : tcs_status_flags_checker

bind tcs_status_flags tcs_status_flags_checker #(.CHANNEL_INDEX(CHANNEL_INDEX)) u_chk (.*);

// [tb/tcs_xfer_model.sv]
// transfer and dma controller stand-in answering the channel a request
`timescale 1ns/1ps
module tcs_xfer_model (
  // clock and request
  input wire logic aclk,
  input wire logic channel_a_interrupt,
  // which controller answers
  input wire logic go_dtc,
  input wire logic go_dma,
  // start pulses
  output logic data_transfer_ctrl_start = 1'b0,
  output logic dma_start = 1'b0
);
  int cnt = 0;
  // starts once per pending request, three cycles late, like a busy controller
  always @(posedge aclk) begin
    data_transfer_ctrl_start <= 1'b0;
    dma_start <= 1'b0;
    if (!channel_a_interrupt || !(go_dtc || go_dma)) cnt <= 0;
    else if (cnt < 3) cnt <= cnt + 1;
    else if (cnt == 3) begin
      data_transfer_ctrl_start <= go_dtc;
      dma_start <= go_dma;
      cnt <= 4;
    end
  end
endmodule : tcs_xfer_model
